// file: logic/buck_supervisor_pkg.sv
package buck_supervisor_pkg;

  // ****************************************
  // Rail indexing
  // ****************************************
  localparam int NUM_BUCK   = 5;
  localparam int NUM_LINEAR = 5;
  localparam int VOLTAGE_SELECT_FIELD_W     = 7;
  localparam int MAP_W      = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic       SINK_LIMIT_RST    = 1'b1;
  localparam logic       THERMAL_EN_RST    = 1'b1;
  localparam logic [4:0] GOOD_MASK_A_RST   = 5'h1E;
  localparam logic       GOOD_MASK_B_RST   = 1'b1;
  localparam logic [2:0] MON_SEL_NONE      = 3'h0;
  localparam logic [2:0] MON_SEL_B1        = 3'h1;
  localparam logic [2:0] MON_SEL_B2        = 3'h2;
  localparam logic [2:0] MON_SEL_B12       = 3'h3;
  localparam logic [2:0] MON_SEL_B3        = 3'h4;
  localparam logic [2:0] MON_SEL_B5        = 3'h5;
  localparam logic [3:0] ADC_CURRENT_CH    = 4'h4;

  // ****************************************
  // Phase control encodings
  // ****************************************
  localparam logic [1:0] PHASE_AUTO   = 2'h0;
  localparam logic [1:0] PHASE_SINGLE = 2'h1;
  localparam logic [1:0] PHASE_DUAL   = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ          = 200;
  localparam int SHORT_MIN_NS     = 155000;
  localparam int SHORT_MAX_NS     = 185000;
  localparam int SHORT_TARGET_NS  = 170000;
  localparam int STARTUP_MASK_NS  = 2000000;
  localparam int SHORT_CYCLES     = (SHORT_TARGET_NS * CLK_MHZ + 999) / 1000;
  localparam int STARTUP_CYCLES   = (STARTUP_MASK_NS * CLK_MHZ + 999) / 1000;
  localparam int SLEW_UV_PER_US   = 2500;
  localparam int VSTEP_UV         = 10000;
  localparam int SLEW_STEP_CYCLES = (VSTEP_UV * CLK_MHZ) / SLEW_UV_PER_US;

endpackage

// file: logic/buck_rail_supervisor_dvs.sv
`timescale 1ns/1ps
// Operation
// - Sink current limit enabled at reset; software may clear it.
// - ADC channel 4 carries current of the single selected buck rail.
// - Thermal monitoring enabled at reset; status shown while enabled.
// - Rails 1 and 2 share one sensor; 3 and 5 own; 4 none.
// - Over-limit on enabled buck rail sets short flag, forces rail off.
// - Any buck short flag raises interrupt unless short mask set.
// - Buck short flags clear on read or reset, releasing the shutoff.
// - Linear rail shorts latch, shut off and clear identically.
// - Shutoff only after short persists between 155 and 185 us.
// - Start-up counter masks shutdown until 2 ms pass without rail enabling.
// - Good output uses voltage plus current, or current only, per type.
// - Each good source maskable; after reset only rail 1 unmasked.
// - Voltage check masked while rail ramps under scaling command.
// - Comparator-mode bit adds ADC current result as a good source.
// - Dual phase: mask bit 0 governs combined rail, bit 1 forced masked.
// - Roof/floor: active pin selects primary, inactive selects alternate.
// - Alternate setting zero turns rail off while selected.
// - Without roof/floor, command bit picks primary or alternate, primary default.
// - Combined rail auto-switches phase by load unless forced single by field; the dual setting still follows load.
// - Primary setting zero disables the buck rail while primary is selected.
module buck_rail_supervisor_dvs #(
  parameter int SHORT_CYC   = buck_supervisor_pkg::SHORT_CYCLES,
  parameter int STARTUP_CYC = buck_supervisor_pkg::STARTUP_CYCLES,
  parameter int SLEW_CYC    = buck_supervisor_pkg::SLEW_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic                                       MCLK,
  input  wire logic                                       RESET_N,
  // Device enable and rail requests
  input  wire logic                                       DEVICE_ENABLE,
  input  wire logic [buck_supervisor_pkg::NUM_BUCK-1:0]   BUCK_ENABLE_REQ,
  input  wire logic [buck_supervisor_pkg::NUM_LINEAR-1:0] LINEAR_ENABLE_REQ,
  // Control pins
  input  wire logic                                       SLEEP_REQUEST_PIN,
  input  wire logic                                       CONTROL_PIN_A,
  input  wire logic                                       CONTROL_PIN_B,
  input  wire logic [buck_supervisor_pkg::MAP_W-1:0]      SLEEP_PIN_RAIL_MAP,
  input  wire logic [buck_supervisor_pkg::MAP_W-1:0]      PIN_A_RAIL_MAP,
  input  wire logic [buck_supervisor_pkg::MAP_W-1:0]      PIN_B_RAIL_MAP,
  // Voltage settings for scaling rails 1, 2, combined and 3
  input  wire logic [4*buck_supervisor_pkg::VOLTAGE_SELECT_FIELD_W-1:0]   PRIMARY_VOLTAGE_SETTING,
  input  wire logic [4*buck_supervisor_pkg::VOLTAGE_SELECT_FIELD_W-1:0]   ALTERNATE_VOLTAGE_SETTING,
  input  wire logic [3:0]                                 ROOF_FLOOR_EN,
  input  wire logic [3:0]                                 FORCE_CMD,
  // Combined rail configuration
  input  wire logic                                       DUAL_PHASE_OTP,
  input  wire logic [1:0]                                 PHASE_FORCE_FIELD,
  input  wire logic                                       HEAVY_LOAD,
  // Software controls
  input  wire logic                                       SINK_LIMIT_DISABLE,
  input  wire logic                                       BUCK_THERMAL_DISABLE,
  input  wire logic [2:0]                                 CURRENT_MONITOR_SELECT,
  input  wire logic                                       SHORT_IRQ_MASK,
  input  wire logic                                       GOOD_TYPE_CURRENT_ONLY,
  input  wire logic                                       ADC_CURRENT_IN_GOOD_EN,
  input  wire logic [4:0]                                 GOOD_SOURCE_MASK_A,
  input  wire logic                                       GOOD_SOURCE_MASK_B,
  input  wire logic                                       MASK_WRITE,
  input  wire logic                                       BUCK_FLAGS_READ,
  input  wire logic                                       LINEAR_FLAGS_READ,
  // Analog sense
  input  wire logic [buck_supervisor_pkg::NUM_BUCK-1:0]   BUCK_OVER_LIMIT,
  input  wire logic [buck_supervisor_pkg::NUM_LINEAR-1:0] LINEAR_OVER_LIMIT,
  input  wire logic [buck_supervisor_pkg::NUM_BUCK-1:0]   BUCK_VOLTAGE_OK,
  input  wire logic                                       ADC_CURRENT_OK,
  input  wire logic [2:0]                                 THERMAL_SENSE,
  // Outputs
  output logic                                            SINK_LIMIT_ENABLE,
  output logic                                            BUCK_THERMAL_ENABLE,
  output logic [2:0]                                      BUCK_THERMAL_FLAGS,
  output logic [2:0]                                      ADC_CH4_RAIL,
  output logic [buck_supervisor_pkg::NUM_BUCK-1:0]        BUCK_SHORT_FLAGS,
  output logic [buck_supervisor_pkg::NUM_LINEAR-1:0]      LINEAR_SHORT_FLAGS,
  output logic [buck_supervisor_pkg::NUM_BUCK-1:0]        BUCK_RAIL_ON,
  output logic [buck_supervisor_pkg::NUM_LINEAR-1:0]      LINEAR_RAIL_ON,
  output logic                                            SHORT_IRQ,
  output logic                                            POWER_GOOD,
  output logic [4*buck_supervisor_pkg::VOLTAGE_SELECT_FIELD_W-1:0]        VOLTAGE_NOW,
  output logic                                            DUAL_PHASE_ACTIVE
);

  localparam int NB = buck_supervisor_pkg::NUM_BUCK;
  localparam int NL = buck_supervisor_pkg::NUM_LINEAR;
  localparam int VW = buck_supervisor_pkg::VOLTAGE_SELECT_FIELD_W;
  localparam int NR = NB + NL;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic pin_for_rail(input logic [3:0] map_s, input logic [3:0] map_a,
                                        input logic [3:0] map_b, input int idx,
                                        input logic ps, input logic pa, input logic pb);
    logic r;
    r = 1'b0;
    if (map_s[idx]) begin
      r = r | ps;
    end
    if (map_a[idx]) begin
      r = r | pa;
    end
    if (map_b[idx]) begin
      r = r | pb;
    end
    return r;
  endfunction

  // ****************************************
  // Software settings
  // ****************************************
  logic [4:0] good_mask_a_q;
  logic       good_mask_b_q;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      good_mask_a_q <= buck_supervisor_pkg::GOOD_MASK_A_RST;
      good_mask_b_q <= buck_supervisor_pkg::GOOD_MASK_B_RST;
    end else if (MASK_WRITE) begin
      good_mask_a_q <= GOOD_SOURCE_MASK_A;
      good_mask_b_q <= GOOD_SOURCE_MASK_B;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SINK_LIMIT_ENABLE   <= buck_supervisor_pkg::SINK_LIMIT_RST;
      BUCK_THERMAL_ENABLE <= buck_supervisor_pkg::THERMAL_EN_RST;
      BUCK_THERMAL_FLAGS  <= 3'h0;
      ADC_CH4_RAIL        <= buck_supervisor_pkg::MON_SEL_NONE;
    end else begin
      SINK_LIMIT_ENABLE   <= !SINK_LIMIT_DISABLE;
      BUCK_THERMAL_ENABLE <= !BUCK_THERMAL_DISABLE;
      // Sensor 0 serves rails 1 and 2 together, 1 serves rail 3, 2 serves rail 5.
      BUCK_THERMAL_FLAGS  <= BUCK_THERMAL_DISABLE ? 3'h0 : THERMAL_SENSE;
      ADC_CH4_RAIL        <= CURRENT_MONITOR_SELECT;
    end
  end

  // ****************************************
  // Start-up short masking counter
  // ****************************************
  logic [NR-1:0] req_q;
  logic [31:0]   start_cnt_q;
  logic          start_mask_q;
  logic          rail_rise;

  assign rail_rise = |({BUCK_ENABLE_REQ, LINEAR_ENABLE_REQ} & ~req_q);

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      req_q        <= '0;
      start_cnt_q  <= 32'h0000_0000;
      start_mask_q <= 1'b1;
    end else begin
      req_q <= {BUCK_ENABLE_REQ, LINEAR_ENABLE_REQ};
      if (!DEVICE_ENABLE || rail_rise) begin
        start_cnt_q  <= 32'h0000_0000;
        start_mask_q <= 1'b1;
      end else if (start_cnt_q >= 32'(STARTUP_CYC - 1)) begin
        start_mask_q <= 1'b0;
      end else begin
        start_cnt_q <= start_cnt_q + 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // Short persistence filter and latched flags
  // ****************************************
  // A counter per rail; one dropout of the comparator restarts it, so a
  // chattering fault is tolerated until it holds steady.
  logic [NR-1:0]  over_all;
  logic [NR-1:0]  en_all;
  logic [NR-1:0]  persist;
  logic [17:0]    filt_q [NR];

  assign over_all = {BUCK_OVER_LIMIT, LINEAR_OVER_LIMIT};

  for (genvar i = 0; i < NR; i++) begin : g_filt
    assign persist[i] = (filt_q[i] >= 18'(SHORT_CYC - 1)) && over_all[i];
    always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
        filt_q[i] <= 18'h0_0000;
      end else if (over_all[i] && en_all[i]) begin
        if (filt_q[i] < 18'(SHORT_CYC - 1)) begin
          filt_q[i] <= filt_q[i] + 18'h0_0001;
        end
      end else begin
        filt_q[i] <= 18'h0_0000;
      end
    end
  end

  logic [NB-1:0] buck_set;
  logic [NL-1:0] lin_set;

  assign buck_set = persist[NR-1:NL] & en_all[NR-1:NL] & {NB{!start_mask_q}};
  assign lin_set  = persist[NL-1:0] & en_all[NL-1:0] & {NL{!start_mask_q}};

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      BUCK_SHORT_FLAGS <= '0;
    end else begin
      // A new short arriving during the read stays set.
      BUCK_SHORT_FLAGS <= (BUCK_FLAGS_READ ? '0 : BUCK_SHORT_FLAGS) | buck_set;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LINEAR_SHORT_FLAGS <= '0;
    end else begin
      LINEAR_SHORT_FLAGS <= (LINEAR_FLAGS_READ ? '0 : LINEAR_SHORT_FLAGS) | lin_set;
    end
  end

  assign SHORT_IRQ = |BUCK_SHORT_FLAGS && !SHORT_IRQ_MASK;

  // ****************************************
  // Voltage target selection and slewing
  // ****************************************
  logic [3:0]    dvs_sel_primary;
  logic [VW-1:0] target   [4];
  logic [VW-1:0] vnow_q   [4];
  logic [15:0]   slew_q   [4];
  logic [3:0]    ramping;
  logic [3:0]    dvs_off;

  for (genvar r = 0; r < 4; r++) begin : g_dvs
    always_comb begin
      if (ROOF_FLOOR_EN[r]) begin
        dvs_sel_primary[r] = pin_for_rail(SLEEP_PIN_RAIL_MAP, PIN_A_RAIL_MAP, PIN_B_RAIL_MAP,
                                          r, SLEEP_REQUEST_PIN, CONTROL_PIN_A,
                                          CONTROL_PIN_B);
      end else begin
        dvs_sel_primary[r] = !FORCE_CMD[r];
      end
    end
    assign target[r]  = dvs_sel_primary[r] ? PRIMARY_VOLTAGE_SETTING[r*VW +: VW]
                                           : ALTERNATE_VOLTAGE_SETTING[r*VW +: VW];
    assign dvs_off[r] = (target[r] == '0);
    assign ramping[r] = !dvs_off[r] && (vnow_q[r] != target[r]);
    assign VOLTAGE_NOW[r*VW +: VW] = vnow_q[r];

    always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
        vnow_q[r] <= '0;
        slew_q[r] <= 16'h0000;
      end else if (dvs_off[r]) begin
        vnow_q[r] <= '0;
        slew_q[r] <= 16'h0000;
      end else if (vnow_q[r] == '0) begin
        vnow_q[r] <= target[r];
        slew_q[r] <= 16'h0000;
      end else if (ramping[r]) begin
        if (slew_q[r] >= 16'(SLEW_CYC - 1)) begin
          slew_q[r] <= 16'h0000;
          vnow_q[r] <= (vnow_q[r] < target[r]) ? vnow_q[r] + VW'(1)
                                               : vnow_q[r] - VW'(1);
        end else begin
          slew_q[r] <= slew_q[r] + 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // Rail enables and phase control
  // ****************************************
  logic [NB-1:0] buck_run;

  always_comb begin
    buck_run = BUCK_ENABLE_REQ;
    // Index 0..1 single rails, index 2 is rail 3; the combined rail drives index 0.
    buck_run[0] = BUCK_ENABLE_REQ[0] && !dvs_off[DUAL_PHASE_OTP ? 2 : 0];
    buck_run[1] = BUCK_ENABLE_REQ[1] && !dvs_off[1] && !DUAL_PHASE_OTP;
    buck_run[2] = BUCK_ENABLE_REQ[2] && !dvs_off[3];
  end

  assign en_all         = {buck_run, LINEAR_ENABLE_REQ};
  assign BUCK_RAIL_ON   = buck_run & ~BUCK_SHORT_FLAGS;
  assign LINEAR_RAIL_ON = LINEAR_ENABLE_REQ & ~LINEAR_SHORT_FLAGS;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DUAL_PHASE_ACTIVE <= 1'b0;
    end else if (!DUAL_PHASE_OTP) begin
      DUAL_PHASE_ACTIVE <= 1'b0;
    end else begin
      case (PHASE_FORCE_FIELD)
        buck_supervisor_pkg::PHASE_SINGLE: DUAL_PHASE_ACTIVE <= 1'b0;
        // Forcing dual phase into no load is unstable, so it still needs load.
        buck_supervisor_pkg::PHASE_DUAL:   DUAL_PHASE_ACTIVE <= HEAVY_LOAD;
        default:                           DUAL_PHASE_ACTIVE <= HEAVY_LOAD;
      endcase
    end
  end

  // ****************************************
  // Power good
  // ****************************************
  logic [NB-1:0] eff_mask;
  logic [NB-1:0] src_good;
  logic [NB-1:0] v_ramp;

  always_comb begin
    v_ramp    = '0;
    v_ramp[0] = ramping[DUAL_PHASE_OTP ? 2 : 0];
    v_ramp[1] = ramping[1];
    v_ramp[2] = ramping[3];
    eff_mask  = good_mask_a_q;
    if (DUAL_PHASE_OTP) begin
      eff_mask[1] = 1'b1;
    end
  end

  for (genvar k = 0; k < NB; k++) begin : g_good
    assign src_good[k] = eff_mask[k] || (!BUCK_OVER_LIMIT[k] &&
                         (GOOD_TYPE_CURRENT_ONLY || BUCK_VOLTAGE_OK[k] || v_ramp[k]));
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      POWER_GOOD <= 1'b0;
    end else begin
      POWER_GOOD <= &src_good && (good_mask_b_q || !ADC_CURRENT_IN_GOOD_EN ||
                    ADC_CURRENT_OK);
    end
  end

endmodule // buck_rail_supervisor_dvs

// file: verification/buck_supervisor_assertions.sv
`timescale 1ns/1ps
module buck_supervisor_assertions #(
  parameter int SHORT_CYC = 8
) (
  // Clock and reset
  input wire logic       MCLK,
  input wire logic       RESET_N,
  // Software controls and buck over-limit sense
  input wire logic       SINK_LIMIT_DISABLE,
  input wire logic       BUCK_THERMAL_DISABLE,
  input wire logic [2:0] CURRENT_MONITOR_SELECT,
  input wire logic       SHORT_IRQ_MASK,
  input wire logic [4:0] GOOD_SOURCE_MASK_A,
  input wire logic       MASK_WRITE,
  input wire logic       BUCK_FLAGS_READ,
  input wire logic [4:0] BUCK_OVER_LIMIT,
  // Watched outputs
  input wire logic       SINK_LIMIT_ENABLE,
  input wire logic       BUCK_THERMAL_ENABLE,
  input wire logic [2:0] ADC_CH4_RAIL,
  input wire logic [4:0] BUCK_SHORT_FLAGS,
  input wire logic [4:0] LINEAR_SHORT_FLAGS,
  input wire logic [4:0] BUCK_RAIL_ON,
  input wire logic [4:0] LINEAR_RAIL_ON,
  input wire logic       SHORT_IRQ,
  input wire logic       POWER_GOOD
);
  // ****************************************
  // Helper state
  // ****************************************
  logic [4:0]  mask_a_q;
  int unsigned run_q;
  // The mask is shadowed here because the design keeps it internally.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) mask_a_q <= buck_supervisor_pkg::GOOD_MASK_A_RST;
    else if (MASK_WRITE) mask_a_q <= GOOD_SOURCE_MASK_A;
  end
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) run_q <= 0;
    else if (BUCK_OVER_LIMIT[0]) run_q <= run_q + 1;
    else run_q <= 0;
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  sequence read_clean;
    BUCK_FLAGS_READ && (BUCK_OVER_LIMIT == 5'h00);
  endsequence
  sequence flags_gone;
    ##1 (BUCK_SHORT_FLAGS == 5'h00);
  endsequence
  sink_limit_a: assert property ($past(RESET_N) |->
    SINK_LIMIT_ENABLE == !$past(SINK_LIMIT_DISABLE))
    else $error("sink limit enable does not follow its control");
  thermal_en_a: assert property ($past(RESET_N) |->
    BUCK_THERMAL_ENABLE == !$past(BUCK_THERMAL_DISABLE))
    else $error("thermal enable does not follow its control");
  monitor_sel_a: assert property ($past(RESET_N) && $past(CURRENT_MONITOR_SELECT) <= 3'h5
    |-> ADC_CH4_RAIL == $past(CURRENT_MONITOR_SELECT))
    else $error("current channel routes the wrong rail");
  short_off_a: assert property ((BUCK_SHORT_FLAGS & BUCK_RAIL_ON) == 5'h00)
    else $error("buck rail on while its short flag is set");
  linear_off_a: assert property ((LINEAR_SHORT_FLAGS & LINEAR_RAIL_ON) == 5'h00)
    else $error("linear rail on while its short flag is set");
  short_irq_a: assert property ($rose(|BUCK_SHORT_FLAGS) && !SHORT_IRQ_MASK |-> SHORT_IRQ)
    else $error("short interrupt missing");
  read_clear_a: assert property (read_clean |-> flags_gone)
    else $error("short flags survive a read");
  persist_a: assert property ($rose(BUCK_SHORT_FLAGS[0]) |-> run_q >= SHORT_CYC - 1)
    else $error("short flag set before the persistence time");
  good_and_a: assert property (BUCK_OVER_LIMIT[0] && !mask_a_q[0] && !MASK_WRITE
    |=> !POWER_GOOD)
    else $error("power good high with an unmasked rail over limit");
endmodule // buck_supervisor_assertions

bind buck_rail_supervisor_dvs buck_supervisor_assertions #(.SHORT_CYC(SHORT_CYC)) chk (
  .MCLK(MCLK), .RESET_N(RESET_N), .SINK_LIMIT_DISABLE(SINK_LIMIT_DISABLE),
  .BUCK_THERMAL_DISABLE(BUCK_THERMAL_DISABLE), .CURRENT_MONITOR_SELECT(CURRENT_MONITOR_SELECT),
  .SHORT_IRQ_MASK(SHORT_IRQ_MASK), .GOOD_SOURCE_MASK_A(GOOD_SOURCE_MASK_A),
  .MASK_WRITE(MASK_WRITE), .BUCK_FLAGS_READ(BUCK_FLAGS_READ), .BUCK_OVER_LIMIT(BUCK_OVER_LIMIT),
  .SINK_LIMIT_ENABLE(SINK_LIMIT_ENABLE), .BUCK_THERMAL_ENABLE(BUCK_THERMAL_ENABLE),
  .ADC_CH4_RAIL(ADC_CH4_RAIL), .BUCK_SHORT_FLAGS(BUCK_SHORT_FLAGS),
  .LINEAR_SHORT_FLAGS(LINEAR_SHORT_FLAGS), .BUCK_RAIL_ON(BUCK_RAIL_ON),
  .LINEAR_RAIL_ON(LINEAR_RAIL_ON), .SHORT_IRQ(SHORT_IRQ), .POWER_GOOD(POWER_GOOD));

// file: verification/rail_load_model.sv
`timescale 1ns/1ps
module rail_load_model (
  // Rail state from the supervisor
  input  wire logic [4:0] rail_on,
  input  wire logic [4:0] lin_on,
  // Fault commands from the bench
  input  wire logic [4:0] short_cmd,
  input  wire logic [4:0] lin_short_cmd,
  // Sense lines back to the supervisor
  output logic      [4:0] over_limit,
  output logic      [4:0] lin_over_limit,
  output logic      [4:0] volt_ok
);
  // A shorted output only draws excess current while its regulator runs.
  assign over_limit     = rail_on & short_cmd;
  assign lin_over_limit = lin_on & lin_short_cmd;
  // A rail that is off sits outside its voltage window.
  assign volt_ok        = rail_on;
endmodule // rail_load_model

// file: verification/buck_rail_supervisor_dvs_test.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module buck_rail_supervisor_dvs_test;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  localparam int SC = 8;
  localparam int UC = 20;
  logic mclk = 1'b0, rst_n = 1'b0, dev_en = 1'b1, sleep_pin = 1'b0, pin_a = 1'b0;
  logic sink_dis = 1'b0, therm_dis = 1'b0, irq_mask = 1'b0, cur_only = 1'b0;
  logic adc_good_en = 1'b0, mask_b = 1'b1, mask_wr = 1'b0, bread = 1'b0, lread = 1'b0;
  logic adc_ok = 1'b1, sink_en, therm_en, irq, pg, dual, dual_otp = 1'b0, heavy = 1'b0;
  logic [4:0] buck_req = 5'h1F, lin_req = 5'h1F, mask_a = 5'h1E;
  logic [4:0] short_cmd = 5'h00, lin_short_cmd = 5'h00, over, lover, vok;
  logic [4:0] bflags, lflags, bon, lon;
  logic [3:0] sleep_map = 4'h0, a_map = 4'h0, rf_en = 4'h0, cmd = 4'h0;
  logic [27:0] prim = {4{7'h20}}, alt = {4{7'h20}}, vnow;
  logic [2:0] mon_sel = 3'h0, therm_sense = 3'h0, therm_flags, ch4;
  logic [1:0] phase_f = 2'h0;
  int n_mismatch = 0, samples_checked = 0, tick = 0;

  always #2.5 mclk = ~mclk;

  buck_rail_supervisor_dvs #(.SHORT_CYC(SC), .STARTUP_CYC(UC), .SLEW_CYC(2)) dut (
    .MCLK(mclk), .RESET_N(rst_n), .DEVICE_ENABLE(dev_en), .BUCK_ENABLE_REQ(buck_req),
    .LINEAR_ENABLE_REQ(lin_req), .SLEEP_REQUEST_PIN(sleep_pin), .CONTROL_PIN_A(pin_a),
    .CONTROL_PIN_B(1'b0), .SLEEP_PIN_RAIL_MAP(sleep_map), .PIN_A_RAIL_MAP(a_map),
    .PIN_B_RAIL_MAP(4'h0), .PRIMARY_VOLTAGE_SETTING(prim), .ALTERNATE_VOLTAGE_SETTING(alt),
    .ROOF_FLOOR_EN(rf_en), .FORCE_CMD(cmd), .DUAL_PHASE_OTP(dual_otp),
    .PHASE_FORCE_FIELD(phase_f), .HEAVY_LOAD(heavy), .SINK_LIMIT_DISABLE(sink_dis),
    .BUCK_THERMAL_DISABLE(therm_dis),
    .CURRENT_MONITOR_SELECT(mon_sel), .SHORT_IRQ_MASK(irq_mask),
    .GOOD_TYPE_CURRENT_ONLY(cur_only), .ADC_CURRENT_IN_GOOD_EN(adc_good_en),
    .GOOD_SOURCE_MASK_A(mask_a), .GOOD_SOURCE_MASK_B(mask_b), .MASK_WRITE(mask_wr),
    .BUCK_FLAGS_READ(bread), .LINEAR_FLAGS_READ(lread), .BUCK_OVER_LIMIT(over),
    .LINEAR_OVER_LIMIT(lover), .BUCK_VOLTAGE_OK(vok), .ADC_CURRENT_OK(adc_ok),
    .THERMAL_SENSE(therm_sense), .SINK_LIMIT_ENABLE(sink_en), .BUCK_THERMAL_ENABLE(therm_en),
    .BUCK_THERMAL_FLAGS(therm_flags), .ADC_CH4_RAIL(ch4), .BUCK_SHORT_FLAGS(bflags),
    .LINEAR_SHORT_FLAGS(lflags), .BUCK_RAIL_ON(bon), .LINEAR_RAIL_ON(lon), .SHORT_IRQ(irq),
    .POWER_GOOD(pg), .VOLTAGE_NOW(vnow), .DUAL_PHASE_ACTIVE(dual));

  rail_load_model load (.rail_on(bon), .lin_on(lon), .short_cmd(short_cmd),
    .lin_short_cmd(lin_short_cmd), .over_limit(over), .lin_over_limit(lover), .volt_ok(vok));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pulse_read();
    @(posedge mclk);
    bread <= 1'b1;
    lread <= 1'b1;
    @(posedge mclk);
    bread <= 1'b0;
    lread <= 1'b0;
    cyc(1);
  endtask
  task automatic write_masks(input logic [4:0] a, input logic b);
    @(posedge mclk);
    mask_a <= a;
    mask_b <= b;
    mask_wr <= 1'b1;
    @(posedge mclk);
    mask_wr <= 1'b0;
    cyc(3);
  endtask
  task automatic wait_v(input int r, input logic [6:0] v);
    for (int i = 0; i < 40 && vnow[r*7+:7] !== v; i++) cyc(1);
    `CHK("voltage", v, vnow[r*7+:7])
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    cyc(3);
    `CHK("sink_en", 1'b1, sink_en)
    `CHK("therm_en", 1'b1, therm_en)
    `CHK("bflags", 5'h00, bflags)
    `CHK("pg", 1'b0, pg)
  endtask
  task automatic t_startup();
    @(posedge mclk);
    short_cmd <= 5'h10;
    cyc(UC / 2);
    `CHK("bflags", 5'h00, bflags)
    for (int i = 0; i < 60 && bflags[4] !== 1'b1; i++) cyc(1);
    `CHK("bflags", 5'h10, bflags)
    @(posedge mclk);
    short_cmd <= 5'h00;
    pulse_read();
    `CHK("bon", 5'h1F, bon)
  endtask
  task automatic t_short();
    @(posedge mclk);
    short_cmd <= 5'h01;
    cyc(SC - 3);
    short_cmd <= 5'h00;
    cyc(3);
    `CHK("bflags", 5'h00, bflags)
    short_cmd <= 5'h01;
    lin_short_cmd <= 5'h02;
    for (int i = 0; i < SC + 10 && bflags[0] !== 1'b1; i++) cyc(1);
    cyc(2);
    `CHK("bflags", 5'h01, bflags)
    `CHK("bon0", 1'b0, bon[0])
    `CHK("irq", 1'b1, irq)
    `CHK("lflags", 5'h02, lflags)
    `CHK("lon1", 1'b0, lon[1])
    irq_mask <= 1'b1;
    cyc(1);
    `CHK("irq", 1'b0, irq)
    short_cmd <= 5'h00;
    lin_short_cmd <= 5'h00;
    irq_mask <= 1'b0;
    pulse_read();
    `CHK("bflags", 5'h00, bflags)
    `CHK("lflags", 5'h00, lflags)
    `CHK("bon", 5'h1F, bon)
    `CHK("lon", 5'h1F, lon)
  endtask
  task automatic t_controls();
    @(posedge mclk);
    sink_dis <= 1'b1;
    therm_sense <= 3'h5;
    cyc(2);
    `CHK("sink_en", 1'b0, sink_en)
    `CHK("therm_flags", 3'h5, therm_flags)
    therm_dis <= 1'b1;
    cyc(2);
    `CHK("therm_en", 1'b0, therm_en)
    `CHK("therm_flags", 3'h0, therm_flags)
    // Channels are switched only while every rail sits at a steady voltage.
    for (int s = 0; s < 6; s++) begin
      mon_sel <= 3'(s);
      cyc(2);
      `CHK("ch4", 3'(s), ch4)
    end
  endtask
  task automatic t_good();
    `CHK("pg", 1'b1, pg)
    buck_req <= 5'h1D;
    cyc(3);
    `CHK("pg", 1'b1, pg)
    write_masks(5'h00, 1'b1);
    `CHK("pg", 1'b0, pg)
    cur_only <= 1'b1;
    adc_ok <= 1'b0;
    cyc(3);
    `CHK("pg", 1'b1, pg)
    adc_good_en <= 1'b1;
    write_masks(5'h00, 1'b0);
    `CHK("pg", 1'b0, pg)
    adc_ok <= 1'b1;
    cyc(3);
    `CHK("pg", 1'b1, pg)
    cur_only <= 1'b0;
    buck_req <= 5'h1F;
    write_masks(5'h1E, 1'b1);
  endtask
  task automatic t_phase();
    buck_req <= 5'h1D;
    write_masks(5'h00, 1'b1);
    `CHK("pg", 1'b0, pg)
    dual_otp <= 1'b1;
    heavy <= 1'b1;
    cyc(2);
    `CHK("dual", 1'b1, dual)
    `CHK("pg", 1'b1, pg)
    phase_f <= 2'h1;
    cyc(2);
    `CHK("dual", 1'b0, dual)
    phase_f <= 2'h2;
    heavy <= 1'b0;
    cyc(2);
    `CHK("dual", 1'b0, dual)
    dual_otp <= 1'b0;
    heavy <= 1'b1;
    phase_f <= 2'h0;
    buck_req <= 5'h1F;
    write_masks(5'h1E, 1'b1);
    `CHK("dual", 1'b0, dual)
  endtask
  task automatic t_dvs();
    alt[21+:7] <= 7'h22;
    cmd[3] <= 1'b1;
    wait_v(3, 7'h22);
    rf_en <= 4'h9;
    sleep_map <= 4'h8;
    sleep_pin <= 1'b1;
    a_map <= 4'h1;
    alt[0+:7] <= 7'h21;
    wait_v(3, 7'h20);
    wait_v(0, 7'h21);
    sleep_pin <= 1'b0;
    pin_a <= 1'b1;
    wait_v(3, 7'h22);
    wait_v(0, 7'h20);
    alt[21+:7] <= 7'h00;
    prim[0+:7] <= 7'h00;
    cyc(3);
    `CHK("bon2", 1'b0, bon[2])
    `CHK("bon0", 1'b0, bon[0])
  endtask

  // ****************************************
  // Run control
  // ****************************************
  // The whole run is under 130 cycles, so this ceiling only trips on a hang.
  always @(posedge mclk) begin
    tick <= tick + 1;
    if (tick == 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    t_reset();
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_startup();
    t_short();
    t_controls();
    t_good();
    t_phase();
    t_dvs();
    give_verdict();
  end
endmodule // buck_rail_supervisor_dvs_test
